// ### src/ebiu_pkg.sv
// package for the external bus interface unit: constants and state types
package ebiu_pkg;
  localparam int unsigned NREG   = 6;            // number of select regions
  localparam int unsigned PAGE_LSB = 10;         // page compare starts at this address bit
  localparam int unsigned WS_W   = 4;            // wait-state count width
  localparam int unsigned TMR_W  = 16;           // interval timer width
  localparam int unsigned LINE_WORDS = 4;        // words in one cache line refill
  localparam logic [1:0] LINE_LAST = 2'h3;       // index of last refill word
  localparam logic [3:0] BE_NONE   = 4'hf;       // no byte lane active (active low)
  localparam logic [TMR_W-1:0] TMR_RST = 16'h0000;

  typedef enum logic [2:0] {
    EBIU_IDLE  = 3'b000,
    EBIU_ADDR  = 3'b001,
    EBIU_DATA  = 3'b010,
    EBIU_GRANT = 3'b011,
    EBIU_REL   = 3'b100
  } ebiu_state_t;

  typedef enum logic [1:0] {
    EBIU_SRC_NONE = 2'b00,
    EBIU_SRC_RD   = 2'b01,
    EBIU_SRC_WB   = 2'b10,
    EBIU_SRC_PF   = 2'b11
  } ebiu_src_t;
endpackage : ebiu_pkg

// ### src/ebiu_top.sv
// external bus interface unit: runs core and cache requests on the external bus
// Operation
// RL1: every external read or write starts by asserting address_strobe_n.
// RL2: read_not_write shows the transfer direction during each transaction.
// RL3: active-low byte_lane_enables give the bytes and width of the transfer.
// RL4: drive address and address_space_tag, drive data on stores, sample on loads.
// RL5: a transaction ends only on ready, external or internal wait-state generated.
// RL6: atomic load-store is a read then write with nothing in between.
// RL7: lock asserted while consecutive operations must not be split.
// RL8: on bus_request_n the unit floats its drivers and asserts bus_grant_n.
// RL9: bus_grant_n deasserts one cycle after bus_request_n deasserts; the unit takes five cycles, through the three-stage synchronizer.
// RL10: six regions, range and mask each, assert matching region_select_n; buffered and atomic writes assert none.
// RL11: a configured region generates ready after its programmed wait states; buffered and atomic writes get no internal ready; later refill words wait none.
// RL12: a programmable timer pulses interval_tick_n once per interval.
// RL13: page_hit_n asserted when the page matches the previous transaction's page.
// RL14: a one-word write buffer lets the core continue while a store completes.
// RL15: a one-word prefetch buffer serves instruction fetches only.
// RL16: separate control bits enable the write buffer and the prefetch buffer.
// RL17: read data goes to cache and core in the same cycle.
// RL18: a 16-byte line refill runs as four single-word transfers.
// RL19: the unit is always serving, arbitrating or idle.
// RL20: an 8-bit address space tag accompanies every 32-bit address.
// RL21: big-endian lanes: address 0 is the most significant byte.
// RL22: a buffered write completes before any later read starts.
module ebiu_top (
  // clock and reset
  input  wire logic                         i_clk,
  input  wire logic                         i_reset_n,
  // configuration
  input  wire logic                         i_wbuf_en,
  input  wire logic                         i_pfbuf_en,
  input  wire logic [ebiu_pkg::NREG*32-1:0] i_region_base,
  input  wire logic [ebiu_pkg::NREG*32-1:0] i_region_mask,
  input  wire logic [ebiu_pkg::NREG*ebiu_pkg::WS_W-1:0] i_region_wait,
  input  wire logic [ebiu_pkg::NREG-1:0]    i_region_en,
  input  wire logic [ebiu_pkg::TMR_W-1:0]   i_tick_reload,
  // core and cache request
  input  wire logic                         i_req,
  input  wire logic                         i_req_write,
  input  wire logic                         i_req_fetch,
  input  wire logic                         i_req_line,
  input  wire logic                         i_req_atomic,
  input  wire logic [1:0]                   i_req_size,
  input  wire logic [31:0]                  i_req_addr,
  input  wire logic [7:0]                   i_req_tag,
  input  wire logic [31:0]                  i_req_wdata,
  output logic                              o_req_ack,
  output logic                              o_rd_valid,
  output logic [31:0]                       o_rd_data,
  output logic                              o_busy,
  // external bus
  output logic                              o_address_strobe_n,
  output logic                              o_read_not_write,
  output logic [3:0]                        o_byte_lane_enables,
  output logic [31:0]                       o_addr,
  output logic [7:0]                        o_address_space_tag,
  output logic                              o_bus_oe,
  output logic [31:0]                       o_data,
  output logic                              o_data_oe,
  input  wire logic [31:0]                  i_data,
  input  wire logic                         i_ready_n,
  output logic                              o_ready_n,
  output logic                              o_ready_oe,
  output logic                              o_lock_n,
  input  wire logic                         i_bus_request_n,
  output logic                              o_bus_grant_n,
  output logic [ebiu_pkg::NREG-1:0]         o_region_select_n,
  output logic                              o_interval_tick_n,
  output logic                              o_page_hit_n
);

  typedef struct packed {
    ebiu_pkg::ebiu_state_t      st;
    ebiu_pkg::ebiu_src_t        src;
    logic [2:0]                 rdy_sync;
    logic [2:0]                 bus_request_n_sync;
    logic                       rdy_q;
    logic                       bus_request_n_q;
    logic                       as_n;
    logic                       rnw;
    logic [3:0]                 be_n;
    logic [31:0]                addr;
    logic [7:0]                 tag;
    logic                       bus_oe;
    logic [31:0]                dout;
    logic                       dout_oe;
    logic                       int_rdy_n;
    logic                       int_rdy_oe;
    logic [ebiu_pkg::WS_W-1:0]  ws_cnt;
    logic                       ws_act;
    logic                       lock_n;
    logic                       atomic_wr;
    logic                       grant_n;
    logic [ebiu_pkg::NREG-1:0]  cs_n;
    logic                       page_hit_n;
    logic [31:0]                last_addr;
    logic                       wb_full;
    logic [31:0]                wb_addr;
    logic [7:0]                 wb_tag;
    logic [31:0]                wb_data;
    logic [3:0]                 wb_be;
    logic                       pf_full;
    logic [31:0]                pf_addr;
    logic [31:0]                pf_data;
    logic [1:0]                 line_idx;
    logic                       line_act;
    logic                       ack;
    logic                       rd_valid;
    logic [31:0]                rd_data;
    logic [ebiu_pkg::TMR_W-1:0] tmr;
    logic                       tick_n;
  } ebiu_regs_t;

  ebiu_regs_t r_r;
  ebiu_regs_t r_nxt;

  logic [ebiu_pkg::NREG-1:0] hit;
  logic [3:0]                be_req;
  logic                      rdy_edge;
  logic                      bus_request_n_lvl;

  // region match per select window
  genvar g;
  generate
    for (g = 0; g < ebiu_pkg::NREG; g++) begin : g_region
      assign hit[g] = i_region_en[g] &
        (((i_req_addr ^ i_region_base[g*32 +: 32]) & ~i_region_mask[g*32 +: 32]) == 32'h0); // RL10
    end
  endgenerate

  // big-endian lanes, active low: offset 0 is lane 3 (d31..24)
  always_comb begin
    unique case (i_req_size)
      2'h0:    be_req = ~(4'h8 >> i_req_addr[1:0]); // RL21
      2'h1:    be_req = i_req_addr[1] ? 4'hc : 4'h3; // RL21
      default: be_req = 4'h0; // RL3
    endcase
  end

  // ready and bus request pass three stages; a change counts when stages two and three agree
  assign rdy_edge = (r_r.rdy_sync[2:1] == 2'b00);
  assign bus_request_n_lvl = (r_r.bus_request_n_sync[2:1] == 2'b00) ? 1'b1 :
                    (r_r.bus_request_n_sync[2:1] == 2'b11) ? 1'b0 : r_r.bus_request_n_q;

  // next state
  always_comb begin
    logic [ebiu_pkg::WS_W-1:0] wsel;
    logic                      anyhit;
    logic                      done;
    wsel   = '0;
    anyhit = 1'b0;
    done   = 1'b0;
    r_nxt  = r_r;
    r_nxt.rdy_sync  = {r_r.rdy_sync[1:0], i_ready_n};
    r_nxt.bus_request_n_sync = {r_r.bus_request_n_sync[1:0], i_bus_request_n};
    r_nxt.bus_request_n_q    = bus_request_n_lvl;
    r_nxt.ack       = 1'b0;
    r_nxt.rd_valid  = 1'b0;
    r_nxt.int_rdy_n = 1'b1;
    r_nxt.int_rdy_oe = 1'b0;
    for (int k = 0; k < ebiu_pkg::NREG; k++) begin
      if (hit[k] && !anyhit) begin
        wsel   = i_region_wait[k*ebiu_pkg::WS_W +: ebiu_pkg::WS_W];
        anyhit = 1'b1;
      end
    end

    // interval timer, one-cycle low pulse per reload period
    r_nxt.tick_n = 1'b1;
    if (r_r.tmr == ebiu_pkg::TMR_RST) begin
      r_nxt.tmr    = i_tick_reload; // RL12
      r_nxt.tick_n = 1'b0; // RL12
    end else begin
      r_nxt.tmr = r_r.tmr - 1'b1;
    end

    unique case (r_r.st)
      ebiu_pkg::EBIU_IDLE: begin // RL19
        r_nxt.as_n = 1'b1;
        if (bus_request_n_lvl && !r_r.atomic_wr) begin
          r_nxt.st      = ebiu_pkg::EBIU_GRANT;
          r_nxt.bus_oe  = 1'b0; // RL8
          r_nxt.dout_oe = 1'b0;
          r_nxt.grant_n = 1'b0; // RL8
        end else if (r_r.atomic_wr || (r_r.wb_full && !(i_req && !i_req_write && !r_r.atomic_wr))
                     || (r_r.wb_full && i_req)) begin
          // buffered or atomic write goes out before any later read
          r_nxt.st      = ebiu_pkg::EBIU_ADDR; // RL22
          r_nxt.src     = ebiu_pkg::EBIU_SRC_WB;
          r_nxt.rnw     = 1'b0; // RL2
          r_nxt.addr    = r_r.wb_addr;
          r_nxt.tag     = r_r.wb_tag; // RL20
          r_nxt.be_n    = r_r.wb_be;
          r_nxt.dout    = r_r.wb_data; // RL4
          r_nxt.dout_oe = 1'b1;
          r_nxt.as_n    = 1'b0; // RL1
        end else if (i_req && i_req_fetch && r_r.pf_full && i_pfbuf_en && r_r.pf_addr == i_req_addr) begin
          r_nxt.rd_valid = 1'b1; // RL15
          r_nxt.rd_data  = r_r.pf_data;
          r_nxt.ack      = 1'b1;
          r_nxt.pf_full  = 1'b0;
        end else if (i_req && i_req_write && i_wbuf_en && !i_req_atomic) begin
          r_nxt.wb_full = 1'b1; // RL14
          r_nxt.wb_addr = i_req_addr;
          r_nxt.wb_tag  = i_req_tag;
          r_nxt.wb_data = i_req_wdata;
          r_nxt.wb_be   = be_req;
          r_nxt.ack     = 1'b1; // RL16
        end else if (i_req) begin
          r_nxt.st       = ebiu_pkg::EBIU_ADDR;
          r_nxt.src      = i_req_write ? ebiu_pkg::EBIU_SRC_WB : ebiu_pkg::EBIU_SRC_RD;
          r_nxt.rnw      = !i_req_write; // RL2
          r_nxt.addr     = (i_req_line && !i_req_write) ? {i_req_addr[31:4], 4'h0} : i_req_addr; // RL4 RL18
          r_nxt.tag      = i_req_tag; // RL20
          r_nxt.be_n     = i_req_line ? 4'h0 : be_req; // RL3
          r_nxt.dout     = i_req_wdata;
          r_nxt.dout_oe  = i_req_write;
          r_nxt.as_n     = 1'b0; // RL1
          r_nxt.bus_oe   = 1'b1;
          r_nxt.line_act = i_req_line && !i_req_write; // RL18
          r_nxt.line_idx = 2'h0;
          r_nxt.lock_n   = !(i_req_atomic && !i_req_write); // RL7
          if (i_req_atomic && !i_req_write) begin
            r_nxt.wb_addr = i_req_addr; // RL6
            r_nxt.wb_tag  = i_req_tag;
            r_nxt.wb_data = i_req_wdata;
            r_nxt.wb_be   = be_req;
          end
        end else if (i_pfbuf_en && !r_r.pf_full && r_r.src == ebiu_pkg::EBIU_SRC_PF) begin
          // prefetch of the next instruction word after a fetch
          r_nxt.st   = ebiu_pkg::EBIU_ADDR; // RL15
          r_nxt.rnw  = 1'b1;
          r_nxt.addr = r_r.pf_addr;
          r_nxt.be_n = 4'h0;
          r_nxt.as_n = 1'b0; // RL1
        end
        if (r_nxt.as_n == 1'b0) begin
          r_nxt.page_hit_n = (r_nxt.addr[31:ebiu_pkg::PAGE_LSB] != r_r.last_addr[31:ebiu_pkg::PAGE_LSB]); // RL13
          r_nxt.last_addr  = r_nxt.addr;
          r_nxt.cs_n       = ~hit; // RL10
          r_nxt.ws_cnt     = wsel;
          r_nxt.ws_act     = anyhit;
          r_nxt.bus_oe     = 1'b1;
          if (r_r.wb_full || r_r.atomic_wr) begin
            r_nxt.cs_n = '1;
            r_nxt.ws_act = 1'b0;
          end
        end
      end
      ebiu_pkg::EBIU_ADDR: begin
        r_nxt.as_n = 1'b1; // strobe is one cycle
        r_nxt.st   = ebiu_pkg::EBIU_DATA;
      end
      ebiu_pkg::EBIU_DATA: begin
        // internal ready held on the shared pin until recognised: a one-cycle pulse never passes the filter
        if (r_r.ws_act) begin
          if (r_r.ws_cnt == '0) begin
            r_nxt.int_rdy_n  = 1'b0; // RL11
            r_nxt.int_rdy_oe = 1'b1;
          end else begin
            r_nxt.ws_cnt = r_r.ws_cnt - 1'b1; // RL11
          end
        end
        done = rdy_edge && !r_r.rdy_q; // RL5
        r_nxt.rdy_q = rdy_edge;
        if (done) begin
          r_nxt.rdy_q   = 1'b0;
          r_nxt.int_rdy_n  = 1'b1;
          r_nxt.int_rdy_oe = 1'b0;
          r_nxt.ws_act  = 1'b0;
          r_nxt.dout_oe = 1'b0;
          r_nxt.cs_n    = '1;
          r_nxt.st      = ebiu_pkg::EBIU_IDLE;
          if (r_r.rnw) begin
            if (r_r.src == ebiu_pkg::EBIU_SRC_PF) begin
              r_nxt.pf_full = 1'b1;
              r_nxt.pf_data = i_data;
            end else begin
              r_nxt.rd_valid = 1'b1; // RL17
              r_nxt.rd_data  = i_data; // RL4
            end
            if (r_r.line_act && r_r.line_idx != ebiu_pkg::LINE_LAST) begin
              r_nxt.line_idx = r_r.line_idx + 1'b1; // RL18
              r_nxt.addr     = {r_r.addr[31:4], r_r.line_idx + 1'b1, 2'b00};
              r_nxt.st       = ebiu_pkg::EBIU_ADDR;
              r_nxt.as_n     = 1'b0; // RL1
              r_nxt.ws_cnt   = r_r.ws_cnt;
              r_nxt.ws_act   = (r_r.cs_n != '1);
              r_nxt.cs_n     = r_r.cs_n;
            end else begin
              r_nxt.line_act = 1'b0;
              r_nxt.ack      = (r_r.src != ebiu_pkg::EBIU_SRC_PF) && r_r.lock_n; // RL6
              r_nxt.atomic_wr = !r_r.lock_n; // RL6
              r_nxt.src      = i_req_fetch ? ebiu_pkg::EBIU_SRC_PF : ebiu_pkg::EBIU_SRC_NONE;
              r_nxt.pf_addr  = r_r.addr + 32'h4;
            end
          end else begin
            r_nxt.wb_full   = 1'b0;
            r_nxt.atomic_wr = 1'b0;
            r_nxt.lock_n    = 1'b1; // RL7
            r_nxt.ack       = r_r.src == ebiu_pkg::EBIU_SRC_WB && !r_r.wb_full;
            r_nxt.src       = ebiu_pkg::EBIU_SRC_NONE;
          end
        end
      end
      ebiu_pkg::EBIU_GRANT: begin
        if (!bus_request_n_lvl) begin
          r_nxt.st = ebiu_pkg::EBIU_REL;
        end
      end
      ebiu_pkg::EBIU_REL: begin
        r_nxt.grant_n = 1'b1; // RL9
        r_nxt.st      = ebiu_pkg::EBIU_IDLE;
      end
      default: r_nxt.st = ebiu_pkg::EBIU_IDLE;
    endcase
  end

  // all state in one register
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      r_r          <= '0;
      r_r.rdy_sync <= 3'h7;
      r_r.bus_request_n_sync <= 3'h7;
      r_r.as_n     <= 1'b1;
      r_r.rnw      <= 1'b1;
      r_r.be_n     <= ebiu_pkg::BE_NONE;
      r_r.int_rdy_n <= 1'b1;
      r_r.lock_n   <= 1'b1;
      r_r.grant_n  <= 1'b1;
      r_r.cs_n     <= '1;
      r_r.page_hit_n <= 1'b1;
      r_r.tick_n   <= 1'b1;
    end else begin
      r_r <= r_nxt;
    end
  end

  // outputs straight from the state register
  assign o_req_ack           = r_r.ack;
  assign o_rd_valid          = r_r.rd_valid;
  assign o_rd_data           = r_r.rd_data;
  assign o_busy              = r_r.wb_full;
  assign o_address_strobe_n  = r_r.as_n;
  assign o_read_not_write    = r_r.rnw;
  assign o_byte_lane_enables = r_r.be_n;
  assign o_addr              = r_r.addr;
  assign o_address_space_tag = r_r.tag;
  assign o_bus_oe            = r_r.bus_oe;
  assign o_data              = r_r.dout;
  assign o_data_oe           = r_r.dout_oe;
  assign o_ready_n           = r_r.int_rdy_n;
  assign o_ready_oe          = r_r.int_rdy_oe;
  assign o_lock_n            = r_r.lock_n;
  assign o_bus_grant_n       = r_r.grant_n;
  assign o_region_select_n   = r_r.cs_n;
  assign o_interval_tick_n   = r_r.tick_n;
  assign o_page_hit_n        = r_r.page_hit_n;

endmodule : ebiu_top

// ### dv/ebiu_top_monitor.sv
// assertion checker for the external bus interface unit ports
module ebiu_top_monitor (
  // clock and reset
  input wire logic                      i_clk,
  input wire logic                      i_reset_n,
  // inputs seen by the unit
  input wire logic                      i_ready_n,
  input wire logic                      i_bus_request_n,
  // outputs of the unit
  input wire logic                      o_address_strobe_n,
  input wire logic                      o_read_not_write,
  input wire logic [3:0]                o_byte_lane_enables,
  input wire logic                      o_bus_oe,
  input wire logic                      o_data_oe,
  input wire logic                      o_ready_n,
  input wire logic                      o_ready_oe,
  input wire logic                      o_lock_n,
  input wire logic                      o_bus_grant_n,
  input wire logic [ebiu_pkg::NREG-1:0] o_region_select_n,
  input wire logic                      o_interval_tick_n,
  input wire logic                      o_rd_valid
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);
  logic [3:0] rdy_age_r;
  logic [3:0] rdy_age_nxt;
  // cycles since the ready wire was low; saturates so a long idle never wraps to a false match
  always_comb rdy_age_nxt = !i_ready_n ? 4'h0 : (&rdy_age_r ? rdy_age_r : rdy_age_r + 4'h1);
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) rdy_age_r <= 4'hf;
    else rdy_age_r <= rdy_age_nxt;
  end
  strobe_pulse_a: assert property ($fell(o_address_strobe_n) |=> o_address_strobe_n)
    else $error("strobe low for more than one cycle");
  write_drive_a: assert property (!o_address_strobe_n && !o_read_not_write |-> o_data_oe && o_bus_oe)
    else $error("store without data drive");
  lane_width_a: assert property (!o_address_strobe_n |-> o_byte_lane_enables != ebiu_pkg::BE_NONE)
    else $error("transfer with no byte lane");
  ready_end_a: assert property (o_rd_valid |-> rdy_age_r < 4'h8)
    else $error("read word without ready");
  lock_start_a: assert property ($fell(o_lock_n) |-> !o_address_strobe_n && o_read_not_write)
    else $error("lock not started by a read strobe");
  lock_end_a: assert property ($rose(o_lock_n) |-> !o_read_not_write)
    else $error("lock released before the write");
  grant_float_a: assert property (!o_bus_grant_n |-> !o_bus_oe && !o_data_oe && o_address_strobe_n)
    else $error("drivers on while granted");
  grant_cause_a: assert property ($fell(o_bus_grant_n) |-> !$past(i_bus_request_n))
    else $error("grant without request");
  grant_release_a: assert property ($rose(i_bus_request_n) |-> ##[1:6] o_bus_grant_n)
    else $error("grant not released");
  wait_ready_a: assert property (o_ready_oe |-> !o_ready_n && o_region_select_n != '1)
    else $error("internal ready outside a region");
  tick_pulse_a: assert property ($fell(o_interval_tick_n) |=> o_interval_tick_n)
    else $error("tick longer than one cycle");
  cover property (!o_lock_n && !o_address_strobe_n);
  cover property (!o_bus_grant_n);
  cover property (o_ready_oe);
endmodule : ebiu_top_monitor

bind ebiu_top ebiu_top_monitor u_mon (.i_clk, .i_reset_n, .i_ready_n, .i_bus_request_n, .o_address_strobe_n,
  .o_read_not_write, .o_byte_lane_enables, .o_bus_oe, .o_data_oe, .o_ready_n, .o_ready_oe, .o_lock_n,
  .o_bus_grant_n, .o_region_select_n, .o_interval_tick_n, .o_rd_valid);

// ### dv/ebiu_mem_model.sv
// external memory model: answers transfers outside the select regions
module ebiu_mem_model #(
  parameter int unsigned DLY = 2,
  parameter logic [31:0] KEY = 32'h5a5a_a5a5
) (
  input  wire logic                      i_clk,
  input  wire logic                      i_as_n,
  input  wire logic [ebiu_pkg::NREG-1:0] i_cs_n,
  input  wire logic [31:0]               i_addr,
  input  wire logic                      i_ready_n,
  input  wire logic                      i_ready_oe,
  output logic                           o_ready_n,
  output logic [31:0]                    o_data
);
  timeunit 1ns;
  timeprecision 1ps;
  int unsigned wait_r = 0;
  int unsigned low_r  = 0;
  int unsigned hold_r = 0;
  logic [31:0] addr_r = 32'h0;
  // wired ready: ours and the unit's own wait-state ready
  assign o_ready_n = (low_r == 0) & (i_ready_oe ? i_ready_n : 1'b1);
  // outside the hold time the lines carry the inverse, so stale data never passes
  assign o_data = hold_r != 0 ? addr_r ^ KEY : ~(addr_r ^ KEY);
  always @(posedge i_clk) begin
    if (low_r != 0) low_r <= low_r - 1;
    if (!i_as_n) begin
      addr_r <= i_addr;
      if (&i_cs_n) wait_r <= DLY + 1;
    end else if (wait_r != 0) begin
      wait_r <= wait_r - 1;
      if (wait_r == 1) low_r <= 3;
    end
    if (!o_ready_n) hold_r <= 5;
    else if (hold_r != 0) hold_r <= hold_r - 1;
  end
endmodule : ebiu_mem_model

// ### dv/ebiu_top_tb.sv
// self-checking bench for the external bus interface unit
module ebiu_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] KEY = 32'h5a5a_a5a5;
  typedef struct packed {logic w; logic [1:0] sz; logic [31:0] a; logic [3:0] be;} ebiu_row_t;
  logic         i_clk = 1'b0, i_reset_n = 1'b0, i_wbuf_en = 1'b0, i_pfbuf_en = 1'b0, i_bus_request_n = 1'b1;
  logic         i_req = 1'b0, i_req_write = 1'b0, i_req_fetch = 1'b0, i_req_line = 1'b0, i_req_atomic = 1'b0;
  logic [1:0]   i_req_size = 2'h0;
  logic [7:0]   i_req_tag = 8'h0;
  logic [31:0]  i_req_addr = 32'h0, i_req_wdata = 32'h0;
  logic [191:0] i_region_base = {160'h0, 32'h8000_0000}, i_region_mask = {160'h0, 32'h0000_ffff};
  logic [23:0]  i_region_wait = 24'h3;
  logic [5:0]   i_region_en = 6'h01;
  logic [15:0]  i_tick_reload = 16'h0009;
  logic         o_req_ack, o_rd_valid, o_busy, o_address_strobe_n, o_read_not_write, o_bus_oe, o_data_oe;
  logic         o_ready_n, o_ready_oe, o_lock_n, o_bus_grant_n, o_interval_tick_n, o_page_hit_n, i_ready_n;
  logic [3:0]   o_byte_lane_enables, cap_be;
  logic [5:0]   o_region_select_n, cap_cs;
  logic [7:0]   o_address_space_tag, cap_tag;
  logic [31:0]  o_rd_data, o_addr, o_data, i_data, cap_a, cap_wd;
  logic         tick_d = 1'b1;
  time          cap_t = 0, rdy_t = 0, tk_a = 0, tk_b = 0;
  logic [31:0]  rd_q [$];
  logic         st_q [$];
  int           err_count = 0, tests_run = 0;
  ebiu_row_t    rows [8] = '{
    '{1'b0, 2'h2, 32'h0000_0100, 4'h0}, '{1'b0, 2'h0, 32'h0000_0101, 4'hb},
    '{1'b0, 2'h0, 32'h0000_0103, 4'he}, '{1'b0, 2'h1, 32'h0000_0102, 4'hc},
    '{1'b1, 2'h0, 32'h0000_0200, 4'h7}, '{1'b1, 2'h1, 32'h0000_0200, 4'h3},
    '{1'b1, 2'h2, 32'h0000_0204, 4'h0}, '{1'b1, 2'h0, 32'h0000_0202, 4'hd}};

  ebiu_top uut (.*);
  ebiu_mem_model #(.DLY(2), .KEY(KEY)) u_mem (.i_clk(i_clk), .i_as_n(o_address_strobe_n),
    .i_cs_n(o_region_select_n), .i_addr(o_addr), .i_ready_n(o_ready_n), .i_ready_oe(o_ready_oe),
    .o_ready_n(i_ready_n), .o_data(i_data));

  // clock at 125 MHz
  always #4 i_clk = ~i_clk;

  // bus observer: values are read one edge late, where they are settled
  always @(posedge i_clk) begin
    tick_d <= o_interval_tick_n;
    if (tick_d && !o_interval_tick_n) begin
      tk_a <= tk_b;
      tk_b <= $time;
    end
    if (o_ready_oe === 1'b1 && rdy_t < cap_t) rdy_t <= $time;
    if (o_rd_valid === 1'b1) rd_q.push_back(o_rd_data);
    if (o_address_strobe_n === 1'b0) begin
      st_q.push_back(o_read_not_write);
      {cap_be, cap_cs, cap_tag, cap_a, cap_wd, cap_t} <= {o_byte_lane_enables, o_region_select_n,
        o_address_space_tag, o_addr, o_data, $time};
    end
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic note(input string s);
    $display("test %s finished at %0t", s, $time);
  endtask : note

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : complete_run

  // one core request, held until acknowledged; entered just after an edge
  task automatic xfer(input logic w, ln, at, input logic [1:0] sz, input logic [31:0] a, wd, output int k);
    {i_req, i_req_write, i_req_line, i_req_atomic, i_req_size} = {1'b1, w, ln, at, sz};
    {i_req_addr, i_req_wdata, i_req_tag} = {a, wd, a[9:2]};
    k = 0;
    do begin
      @(posedge i_clk);
      #1;
      k++;
    end while (o_req_ack !== 1'b1 && k < 300);
    if (k >= 300) check(32'h0, 32'h1);
    i_req = 1'b0;
    @(posedge i_clk);
    #1;
  endtask : xfer

  initial begin
    int k;
    int d;
    repeat (8) @(posedge i_clk);
    #1 i_reset_n = 1'b1;
    check(32'({o_address_strobe_n, o_bus_grant_n, o_lock_n, o_read_not_write, o_byte_lane_enables,
      o_bus_oe, o_data_oe}), 32'h3fc);
    note("reset");
    foreach (rows[n]) begin
      xfer(rows[n].w, 1'b0, 1'b0, rows[n].sz, rows[n].a, ~rows[n].a, k);
      check(32'(cap_be), 32'(rows[n].be));
      check(32'(cap_a[31:2]), 32'(rows[n].a[31:2]));
      check(32'(cap_tag), 32'(rows[n].a[9:2]));
      check(32'(st_q[$]), 32'(!rows[n].w));
      if (rows[n].sz == 2'h2) check(rows[n].w ? cap_wd : rd_q[$], rows[n].w ? ~rows[n].a : rows[n].a ^ KEY);
    end
    note("lanes");
    i_wbuf_en = 1'b1;
    xfer(1'b1, 1'b0, 1'b0, 2'h2, 32'h300, 32'hc0de_0300, k);
    check(32'(k <= 2), 32'h1);
    xfer(1'b0, 1'b0, 1'b0, 2'h2, 32'h304, 32'h0, k);
    check(32'({st_q[$-1], st_q[$]}), 32'h1);
    check(rd_q[$], 32'h304 ^ KEY);
    check(32'(o_page_hit_n), 32'h0);
    i_wbuf_en = 1'b0;
    note("write buffer");
    rd_q.delete();
    xfer(1'b0, 1'b1, 1'b0, 2'h2, 32'h418, 32'h0, k);
    check(32'(rd_q.size()), 32'h4);
    foreach (rd_q[j]) check(rd_q[j], (32'h410 + 32'(j) * 4) ^ KEY);
    note("refill");
    xfer(1'b0, 1'b0, 1'b1, 2'h2, 32'h500, 32'hcafe_0500, k);
    check(32'({st_q[$-1], st_q[$]}), 32'h2);
    check(cap_wd, 32'hcafe_0500);
    check(rd_q[$], 32'h500 ^ KEY);
    note("atomic");
    {i_pfbuf_en, i_req_fetch} = 2'b11;
    xfer(1'b0, 1'b0, 1'b0, 2'h2, 32'h600, 32'h0, k);
    xfer(1'b0, 1'b0, 1'b0, 2'h2, 32'h604, 32'h0, k);
    check(rd_q[$], 32'h604 ^ KEY);
    {i_pfbuf_en, i_req_fetch} = 2'b00;
    note("prefetch");
    for (int wv = 1; wv <= 3; wv += 2) begin
      i_region_wait = 24'(wv);
      xfer(1'b0, 1'b0, 1'b0, 2'h2, 32'h8000_0010, 32'h0, k);
      d = int'((rdy_t - cap_t) / 8);
      check(32'(cap_cs), 32'h3e);
      check(32'(o_page_hit_n), 32'(wv == 1));
      check(32'(d >= wv + 1 && d <= wv + 3), 32'h1);
      check(rd_q[$], 32'h8000_0010 ^ KEY);
    end
    note("regions");
    i_bus_request_n = 1'b0;
    k = 0;
    while (o_bus_grant_n !== 1'b0 && k < 20) begin
      @(posedge i_clk);
      #1;
      k++;
    end
    check(32'({o_bus_grant_n, o_bus_oe}), 32'h0);
    repeat (4) @(posedge i_clk);
    #1 i_bus_request_n = 1'b1;
    k = 0;
    while (o_bus_grant_n !== 1'b1 && k < 20) begin
      @(posedge i_clk);
      #1;
      k++;
    end
    check(32'(k >= 2 && k <= 6), 32'h1);
    note("arbitration");
    check(32'((tk_b - tk_a) / 8), 32'ha);
    note("tick");
    complete_run();
  end

  // watchdog well beyond the few hundred cycles the tests need
  initial begin
    #400000;
    err_count++;
    complete_run();
  end
endmodule : ebiu_top_tb
